/* File: shared/ifev_pkg.sv */
// Constants, register map and types of the interrupt flag/enable/vectoring block.
// Assumes a 250 MHz core clock and an Avalon-MM slave with 32-bit data.
package ifev_pkg;
    localparam int IFEV_NUM_SRC = 17;
    localparam int IFEV_NUM_PERIPH = 14;
    localparam logic [7:0] IFEV_OFS_CTRL = 8'h00;
    localparam logic [7:0] IFEV_OFS_PFLAG1 = 8'h04;
    localparam logic [7:0] IFEV_OFS_PFLAG2 = 8'h08;
    localparam logic [7:0] IFEV_OFS_PEN1 = 8'h0C;
    localparam logic [7:0] IFEV_OFS_PEN2 = 8'h10;
    localparam logic [7:0] IFEV_OFS_ISTAT = 8'h14;
    localparam logic [7:0] IFEV_OFS_IEN = 8'h18;
    localparam logic [7:0] IFEV_OFS_ICLR = 8'h1C;
    localparam logic [7:0] IFEV_OFS_VECTOR = 8'h20;
    localparam int IFEV_BIT_GLOBAL_EN = 7;
    localparam int IFEV_BIT_GROUP_EN = 6;
    localparam int IFEV_BIT_T0IE = 5;
    localparam int IFEV_BIT_EXTIE = 4;
    localparam int IFEV_BIT_PCHIE = 3;
    localparam int IFEV_BIT_T0IF = 2;
    localparam int IFEV_BIT_EXTIF = 1;
    localparam int IFEV_BIT_PCHIF = 0;
    localparam logic [7:0] IFEV_CTRL_RST = 8'h00;
    localparam logic [7:0] IFEV_PFLAG_RST = 8'h00;
    localparam logic [7:0] IFEV_PFLAG2_MASK = 8'hEB;
    localparam logic [12:0] IFEV_VECTOR = 13'h0004;
    localparam logic [12:0] IFEV_PC_RST = 13'h0000;
    localparam int IFEV_CLK_MHZ = 250;
    localparam int IFEV_QPHASE_NS = 100;
    localparam int IFEV_QPHASE_CYC = (IFEV_QPHASE_NS * IFEV_CLK_MHZ) / 1000;
    localparam int IFEV_LAT_MIN_CY = 3;
    localparam int IFEV_LAT_MAX_CY = 4;
    localparam int IFEV_STACK_DEPTH = 8;
    typedef enum logic [1:0] {
        IFEV_RUN = 2'b00,
        IFEV_PEND = 2'b01,
        IFEV_SLEEP = 2'b10
    } ifev_state_e;
endpackage : ifev_pkg

/* File: shared/ifev_phase_if.sv */
// Q-phase timing bundle between the divider and the controller.
// Assumes a single core clock.
`timescale 1ns/1ns
interface ifev_phase_if;
    logic qTick;
    logic [1:0] qPhase;
    logic cycleEnd;
    modport src (output qTick, output qPhase, output cycleEnd);
    modport dst (input qTick, input qPhase, input cycleEnd);
endinterface : ifev_phase_if

/* File: core/ifev_qphase.sv */
// Divider making Q-phase ticks and the instruction-cycle boundary.
// Assumes core_clk at the package rate.
`timescale 1ns/1ns
module ifev_qphase
    import ifev_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    ifev_phase_if.src ph
);
    logic [7:0] divCnt_q;
    logic [1:0] qPhase_q;
    logic tick;

    assign tick = (divCnt_q == 8'(IFEV_QPHASE_CYC - 1));
    assign ph.qTick = tick;
    assign ph.qPhase = qPhase_q;
    assign ph.cycleEnd = tick && (qPhase_q == 2'h3);

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            divCnt_q <= 8'h00;
        end
        else
        begin
            divCnt_q <= tick ? 8'h00 : divCnt_q + 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            qPhase_q <= 2'h0;
        end
        else if (tick)
        begin
            qPhase_q <= qPhase_q + 2'h1;
        end
    end
endmodule : ifev_qphase

/* File: core/ifev_stack.sv */
// Return-address stack for interrupt entries.
// Assumes push and pop are never requested together.
`timescale 1ns/1ns
module ifev_stack
    import ifev_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic push,
    input wire logic pop,
    input wire logic [12:0] pushData,
    output logic [12:0] topData
);
    logic [12:0] mem [IFEV_STACK_DEPTH];
    logic [2:0] ptr_q;
    logic [12:0] top_q;

    assign topData = top_q;

    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[ptr_q] <= pushData;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ptr_q <= 3'h0;
            top_q <= IFEV_PC_RST;
        end
        else if (push)
        begin
            ptr_q <= ptr_q + 3'h1;
            top_q <= pushData;
        end
        else if (pop)
        begin
            ptr_q <= ptr_q - 3'h1;
            top_q <= mem[ptr_q - 3'h2];
        end
    end
endmodule : ifev_stack

/* File: core/ifev_irq_ctrl.sv */
// Interrupt flag, enable and vectoring logic with an Avalon-MM register port.
// Assumes event inputs are pulses on core_clk except the pin and port-change levels.
`timescale 1ns/1ns
module ifev_irq_ctrl
    import ifev_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic avs_response_err,
    input wire logic external_irq_pin,
    input wire logic portChangeIn,
    input wire logic timer0Overflow,
    input wire logic [IFEV_NUM_PERIPH-1:0] periphEvent,
    input wire logic [12:0] corePc,
    input wire logic returnFromIrqInstr,
    input wire logic sleepEnter,
    output logic irqRequest,
    output logic vectorLoad,
    output logic [12:0] vectorPc,
    output logic [12:0] returnPc,
    output logic wakeUp,
    output logic irqOut
);
    ifev_phase_if ph ();
    ifev_qphase u_qphase (.core_clk(core_clk), .rst_b(rst_b), .ph(ph));

    ifev_state_e state_q;
    logic [7:0] irq_control_reg_q;
    logic [7:0] periph_flag_reg1_q;
    logic [7:0] periph_flag_reg2_q;
    logic [7:0] periph_enable_reg1_q;
    logic [7:0] periph_enable_reg2_q;
    logic [2:0] evStat_q;
    logic [2:0] evEn_q;
    logic [2:0] latCnt_q;
    logic [1:0] extSync_q;
    logic [1:0] pchSync_q;
    logic extLevel_q;
    logic pchLevel_q;
    logic [31:0] readData_q;
    logic readAck_q;
    logic readErr_q;
    logic [12:0] vectorPc_q;
    logic vectorLoad_q;
    logic wakeUp_q;
    logic extRise;
    logic pchEdge;
    logic corePair;
    logic periphPair;
    logic anyPending;
    logic takeIrq;
    logic wrAccess;
    logic wrLane0;
    logic [7:0] wByte;
    logic [15:0] periphFlags;
    logic [15:0] periphEnables;
    logic [2:0] evSet;
    logic [7:0] periph2Event;

    // Pin and port inputs come from outside the clock domain
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            extSync_q <= 2'b00;
            pchSync_q <= 2'b00;
            extLevel_q <= 1'b0;
            pchLevel_q <= 1'b0;
        end
        else
        begin
            extSync_q <= {extSync_q[0], external_irq_pin};
            pchSync_q <= {pchSync_q[0], portChangeIn};
            extLevel_q <= extSync_q[1];
            pchLevel_q <= pchSync_q[1];
        end
    end

    assign extRise = extSync_q[1] && !extLevel_q;
    assign pchEdge = pchSync_q[1] != pchLevel_q;

    assign wrAccess = avs_write;
    assign wrLane0 = wrAccess && avs_byteenable[0];
    assign wByte = avs_writedata[7:0];

    assign periphFlags = {periph_flag_reg2_q, periph_flag_reg1_q};
    assign periphEnables = {periph_enable_reg2_q, periph_enable_reg1_q};

    // Core pairs: timer0, pin, port change flags against their enables
    assign corePair = (irq_control_reg_q[IFEV_BIT_T0IF] && irq_control_reg_q[IFEV_BIT_T0IE])
        || (irq_control_reg_q[IFEV_BIT_EXTIF] && irq_control_reg_q[IFEV_BIT_EXTIE])
        || (irq_control_reg_q[IFEV_BIT_PCHIF] && irq_control_reg_q[IFEV_BIT_PCHIE]);
    assign periphPair = irq_control_reg_q[IFEV_BIT_GROUP_EN]
        && |(periphFlags & periphEnables);
    assign anyPending = corePair || periphPair;
    assign irqRequest = irq_control_reg_q[IFEV_BIT_GLOBAL_EN] && anyPending;
    // Take at the fourth boundary so event to vector spans three to four cycles
    assign takeIrq = irqRequest && ph.cycleEnd
        && (state_q == IFEV_PEND) && (latCnt_q >= 3'(IFEV_LAT_MIN_CY));

    // Second flag register has holes at bits 4 and 2; events 13..8 fill the rest
    assign periph2Event = {periphEvent[13:11], 1'b0, periphEvent[10], 1'b0, periphEvent[9:8]};

    // Control register: hardware sets win over software writes
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_control_reg_q <= IFEV_CTRL_RST;
        end
        else
        begin
            logic [7:0] nxt;
            nxt = irq_control_reg_q;
            if (wrLane0 && avs_address == IFEV_OFS_CTRL)
            begin
                nxt = wByte;
            end
            if (takeIrq)
            begin
                nxt[IFEV_BIT_GLOBAL_EN] = 1'b0;
            end
            else if (returnFromIrqInstr)
            begin
                nxt[IFEV_BIT_GLOBAL_EN] = 1'b1;
            end
            if (timer0Overflow)
            begin
                nxt[IFEV_BIT_T0IF] = 1'b1;
            end
            if (extRise)
            begin
                nxt[IFEV_BIT_EXTIF] = 1'b1;
            end
            if (pchEdge)
            begin
                nxt[IFEV_BIT_PCHIF] = 1'b1;
            end
            irq_control_reg_q <= nxt;
        end
    end

    // Peripheral flag and enable registers, one bit per source
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_pflag
            always_ff @(posedge core_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    periph_flag_reg1_q[gi] <= IFEV_PFLAG_RST[gi];
                    periph_flag_reg2_q[gi] <= IFEV_PFLAG_RST[gi];
                end
                else
                begin
                    if (periphEvent[gi])
                    begin
                        periph_flag_reg1_q[gi] <= 1'b1;
                    end
                    else if (wrLane0 && avs_address == IFEV_OFS_PFLAG1)
                    begin
                        periph_flag_reg1_q[gi] <= wByte[gi];
                    end
                    if (periph2Event[gi])
                    begin
                        periph_flag_reg2_q[gi] <= 1'b1;
                    end
                    else if (wrLane0 && avs_address == IFEV_OFS_PFLAG2)
                    begin
                        periph_flag_reg2_q[gi] <= wByte[gi] & IFEV_PFLAG2_MASK[gi];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            periph_enable_reg1_q <= IFEV_PFLAG_RST;
            periph_enable_reg2_q <= IFEV_PFLAG_RST;
        end
        else if (wrLane0 && avs_address == IFEV_OFS_PEN1)
        begin
            periph_enable_reg1_q <= wByte;
        end
        else if (wrLane0 && avs_address == IFEV_OFS_PEN2)
        begin
            periph_enable_reg2_q <= wByte & IFEV_PFLAG2_MASK;
        end
    end

    // Vectoring sequencer: pending requests wait for cycle boundaries
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= IFEV_RUN;
            latCnt_q <= 3'h0;
        end
        else
        begin
            case (state_q)
                IFEV_RUN:
                begin
                    latCnt_q <= 3'h0;
                    if (sleepEnter)
                    begin
                        state_q <= IFEV_SLEEP;
                    end
                    else if (irqRequest)
                    begin
                        state_q <= IFEV_PEND;
                    end
                end
                IFEV_PEND:
                begin
                    if (takeIrq || !irqRequest)
                    begin
                        state_q <= IFEV_RUN;
                    end
                    else if (ph.cycleEnd)
                    begin
                        latCnt_q <= latCnt_q + 3'h1;
                    end
                end
                IFEV_SLEEP:
                begin
                    if (anyPending)
                    begin
                        state_q <= irq_control_reg_q[IFEV_BIT_GLOBAL_EN]
                            ? IFEV_PEND : IFEV_RUN;
                    end
                end
                default:
                begin
                    state_q <= IFEV_RUN;
                end
            endcase
        end
    end

    // Vector and wake-up outputs
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            vectorLoad_q <= 1'b0;
            vectorPc_q <= IFEV_PC_RST;
            wakeUp_q <= 1'b0;
        end
        else
        begin
            vectorLoad_q <= takeIrq;
            wakeUp_q <= (state_q == IFEV_SLEEP) && anyPending;
            if (takeIrq)
            begin
                vectorPc_q <= IFEV_VECTOR;
            end
            else if ((state_q == IFEV_SLEEP) && anyPending)
            begin
                vectorPc_q <= corePc + 13'h0001;
            end
        end
    end

    assign vectorLoad = vectorLoad_q;
    assign vectorPc = vectorPc_q;
    assign wakeUp = wakeUp_q;

    ifev_stack u_stack (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .push(takeIrq),
        .pop(returnFromIrqInstr && !takeIrq),
        .pushData(corePc),
        .topData(returnPc)
    );

    // Bus-side interrupt status: vector taken, wake-up, return executed
    assign evSet = {returnFromIrqInstr, wakeUp_q, vectorLoad_q};
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            evStat_q <= 3'h0;
            evEn_q <= 3'h0;
        end
        else
        begin
            evStat_q <= evSet | (evStat_q & ~((wrLane0 && avs_address == IFEV_OFS_ICLR)
                ? wByte[2:0] : 3'h0));
            if (wrLane0 && avs_address == IFEV_OFS_IEN)
            begin
                evEn_q <= wByte[2:0];
            end
        end
    end
    assign irqOut = |(evStat_q & evEn_q);

    // Reads answer one cycle after request; writes complete at once
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            readData_q <= 32'h0000_0000;
            readAck_q <= 1'b0;
            readErr_q <= 1'b0;
        end
        else
        begin
            readAck_q <= avs_read && !readAck_q;
            readErr_q <= 1'b0;
            readData_q <= 32'h0000_0000;
            if (avs_read && !readAck_q)
            begin
                case (avs_address)
                    IFEV_OFS_CTRL: readData_q <= {24'h00_0000, irq_control_reg_q};
                    IFEV_OFS_PFLAG1: readData_q <= {24'h00_0000, periph_flag_reg1_q};
                    IFEV_OFS_PFLAG2: readData_q <= {24'h00_0000, periph_flag_reg2_q};
                    IFEV_OFS_PEN1: readData_q <= {24'h00_0000, periph_enable_reg1_q};
                    IFEV_OFS_PEN2: readData_q <= {24'h00_0000, periph_enable_reg2_q};
                    IFEV_OFS_ISTAT: readData_q <= {29'h0000_0000, evStat_q};
                    IFEV_OFS_IEN: readData_q <= {29'h0000_0000, evEn_q};
                    IFEV_OFS_ICLR: readData_q <= 32'h0000_0000;
                    IFEV_OFS_VECTOR: readData_q <= {19'h0_0000, returnPc};
                    default: readErr_q <= 1'b1;
                endcase
            end
        end
    end

    assign avs_readdata = readData_q;
    assign avs_response_err = readErr_q;
    assign avs_waitrequest = avs_read && !readAck_q;

    sequence s_vec_entry;
        vectorLoad && vectorPc == IFEV_VECTOR && !irq_control_reg_q[IFEV_BIT_GLOBAL_EN];
    endsequence
    a_entry_clear_en: assert property (@(posedge core_clk) disable iff (!rst_b)
        takeIrq |=> s_vec_entry)
        else $error("vector entry did not clear enable or load 0004h");
    a_global_block_all: assert property (@(posedge core_clk) disable iff (!rst_b)
        !irq_control_reg_q[IFEV_BIT_GLOBAL_EN] |-> !irqRequest)
        else $error("request raised with global enable clear");
    a_req_pair: assert property (@(posedge core_clk) disable iff (!rst_b)
        irq_control_reg_q[IFEV_BIT_GLOBAL_EN] && corePair |-> irqRequest)
        else $error("core pair did not raise request");
    a_ret_sets_en: assert property (@(posedge core_clk) disable iff (!rst_b)
        returnFromIrqInstr && !takeIrq |=> irq_control_reg_q[IFEV_BIT_GLOBAL_EN])
        else $error("return did not set global enable");
    a_flag_sets_ext: assert property (@(posedge core_clk) disable iff (!rst_b)
        extRise |=> irq_control_reg_q[IFEV_BIT_EXTIF])
        else $error("pin flag not set by event");
    a_periph_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
        !irq_control_reg_q[IFEV_BIT_GROUP_EN] && !corePair |-> !irqRequest)
        else $error("peripheral request passed without group enable");
    a_latency_min: assert property (@(posedge core_clk) disable iff (!rst_b)
        takeIrq |-> latCnt_q >= 3'(IFEV_LAT_MIN_CY) && latCnt_q <= 3'(IFEV_LAT_MAX_CY))
        else $error("vector latency outside three to four cycles");
    a_wake_vec: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_q == IFEV_SLEEP && anyPending && !irq_control_reg_q[IFEV_BIT_GLOBAL_EN]
        |=> vectorPc == corePc + 13'h0001 && wakeUp)
        else $error("plain wake-up did not continue at next address");
endmodule : ifev_irq_ctrl

/* File: test/ifev_core_model.sv */
// Behavioural processor core on the far side of the interrupt block.
// Assumes one core clock and an active-low asynchronous reset.
`timescale 1ns/1ns
module ifev_core_model
    import ifev_pkg::*;
#(
    parameter logic [12:0] START_PC = 13'h0123
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic vectorLoad,
    input wire logic [12:0] vectorPc,
    input wire logic [12:0] returnPc,
    input wire logic retCmd,
    output logic [12:0] corePc,
    output logic returnFromIrqInstr
);
    // Program counter follows vector loads and returns, else stays put
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            corePc <= START_PC;
        else if (vectorLoad)
            corePc <= vectorPc;
        else if (returnFromIrqInstr)
            corePc <= returnPc;
    end
    // Return instruction issued one cycle after the bench asks for it
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            returnFromIrqInstr <= 1'b0;
        else
            returnFromIrqInstr <= retCmd;
    end
endmodule : ifev_core_model

/* File: test/tb_interrupt_flag_enable_vectoring.sv */
// Self-checking bench for the interrupt flag, enable and vectoring block.
// Assumes the core model stands in for the processor.
`timescale 1ns/1ns
module tb_interrupt_flag_enable_vectoring
    import ifev_pkg::*;
();
    localparam int INSTR_CYC = 4 * IFEV_QPHASE_CYC;
    logic core_clk, rst_b, avs_read, avs_write, avs_waitrequest, avs_response_err, er;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic external_irq_pin, portChangeIn, timer0Overflow, sleepEnter, retCmd;
    logic [IFEV_NUM_PERIPH-1:0] periphEvent;
    logic [12:0] corePc, vectorPc, returnPc, pcSeen;
    logic returnFromIrqInstr, irqRequest, vectorLoad, wakeUp, irqOut;
    int n_mismatch, checks_done, lat;

    ifev_irq_ctrl dut (.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response_err(avs_response_err), .external_irq_pin(external_irq_pin),
        .portChangeIn(portChangeIn), .timer0Overflow(timer0Overflow),
        .periphEvent(periphEvent), .corePc(corePc), .returnFromIrqInstr(returnFromIrqInstr),
        .sleepEnter(sleepEnter), .irqRequest(irqRequest), .vectorLoad(vectorLoad),
        .vectorPc(vectorPc), .returnPc(returnPc), .wakeUp(wakeUp), .irqOut(irqOut));
    ifev_core_model core (.core_clk(core_clk), .rst_b(rst_b), .vectorLoad(vectorLoad),
        .vectorPc(vectorPc), .returnPc(returnPc), .retCmd(retCmd), .corePc(corePc),
        .returnFromIrqInstr(returnFromIrqInstr));

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic chkRange(input int got, input int lo, input int hi, input string what);
        checks_done++;
        if (got < lo || got > hi)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s %0d outside %0d..%0d", $time, what, got, lo, hi);
        end
    endtask : chkRange

    task automatic timeout();
        n_mismatch++;
        $display("CHECK FAILED at %0t: wait limit used up", $time);
        tally_and_finish();
    endtask : timeout

    // Avalon-MM master cycle; read data and error land in rd and er
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge core_clk);
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= a;
        avs_writedata <= d;
        for (k = 0; k < 20; k++)
        begin
            @(posedge core_clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        if (k == 20)
            timeout();
        rd = avs_readdata;
        er = avs_response_err;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic pulse(input int which);
        @(posedge core_clk);
        case (which)
            0: timer0Overflow <= 1'b1;
            1: sleepEnter <= 1'b1;
            2: retCmd <= 1'b1;
            default: periphEvent <= '1;
        endcase
        @(posedge core_clk);
        {timer0Overflow, sleepEnter, retCmd} <= 3'b000;
        periphEvent <= '0;
    endtask : pulse

    // Counts cycles until the vector load strobe or a wake pulse shows
    task automatic waitFor(input logic wantWake, output int cyc);
        for (cyc = 1; cyc < 1000; cyc++)
        begin
            @(negedge core_clk);
            if ((wantWake ? wakeUp : vectorLoad) === 1'b1)
                return;
        end
        timeout();
    endtask : waitFor

    task automatic test_reset();
        bus(0, IFEV_OFS_CTRL, 0);
        chk(rd, {24'h0, IFEV_CTRL_RST}, "ctrl reset");
        bus(0, IFEV_OFS_PFLAG1, 0);
        chk(rd, {24'h0, IFEV_PFLAG_RST}, "pflag1 reset");
        bus(0, 8'h40, 0);
        chk(rd, 32'h0000_0000, "unmapped read data");
        chk(er, 32'h0000_0001, "unmapped read error");
        $display("test reset done");
    endtask : test_reset

    task automatic test_flags();
        pulse(0);
        pulse(3);
        @(posedge core_clk);
        external_irq_pin <= 1'b1;
        portChangeIn <= 1'b1;
        repeat (8) @(posedge core_clk);
        bus(0, IFEV_OFS_CTRL, 0);
        chk(rd, 32'h0000_0007, "core flags");
        bus(0, IFEV_OFS_PFLAG1, 0);
        chk(rd, 32'h0000_00FF, "pflag1");
        bus(0, IFEV_OFS_PFLAG2, 0);
        chk(rd, {24'h0, IFEV_PFLAG2_MASK}, "pflag2");
        bus(1, IFEV_OFS_PEN1, 32'h0000_00FF);
        bus(1, IFEV_OFS_CTRL, 32'h0000_0040);
        @(negedge core_clk);
        chk(irqRequest, 0, "request without global");
        bus(1, IFEV_OFS_CTRL, 32'h0000_0080);
        @(negedge core_clk);
        chk(irqRequest, 0, "request without group");
        $display("test flags done");
    endtask : test_flags

    task automatic test_vector();
        bus(1, IFEV_OFS_IEN, 32'h0000_0001);
        bus(1, IFEV_OFS_CTRL, 32'h0000_00C0);
        @(negedge core_clk);
        chk(irqRequest, 1, "request enabled");
        waitFor(0, lat);
        chk(vectorPc, IFEV_VECTOR, "vector address");
        chk(returnPc, 13'h0123, "pushed return");
        bus(0, IFEV_OFS_CTRL, 0);
        chk(rd, 32'h0000_0040, "global cleared");
        chk(irqOut, 1, "irq line high");
        bus(1, IFEV_OFS_ICLR, 32'h0000_0001);
        @(negedge core_clk);
        chk(irqOut, 0, "irq line cleared");
        bus(1, IFEV_OFS_PFLAG1, 0);
        bus(1, IFEV_OFS_PFLAG2, 0);
        pulse(2);
        repeat (3) @(posedge core_clk);
        bus(0, IFEV_OFS_CTRL, 0);
        chk(rd, 32'h0000_00C0, "global after return");
        chk(irqRequest, 0, "no recursion");
        bus(0, IFEV_OFS_ISTAT, 0);
        chk(rd, 32'h0000_0004, "return status");
        bus(1, IFEV_OFS_CTRL, 0);
        $display("test vector done");
    endtask : test_vector

    task automatic test_latency();
        for (int i = 0; i < 2; i++)
        begin
            {external_irq_pin, portChangeIn} <= 2'b00;
            repeat (20 + 37 * i) @(posedge core_clk);
            bus(1, IFEV_OFS_CTRL, i ? 32'h0000_0088 : 32'h0000_0090);
            @(posedge core_clk);
            if (i)
                portChangeIn <= 1'b1;
            else
                external_irq_pin <= 1'b1;
            waitFor(0, lat);
            chkRange(lat, IFEV_LAT_MIN_CY * INSTR_CYC,
                IFEV_LAT_MAX_CY * INSTR_CYC + 8, "event latency");
            bus(1, IFEV_OFS_CTRL, 0);
        end
        $display("test latency done");
    endtask : test_latency

    task automatic test_wake();
        bus(1, IFEV_OFS_CTRL, 32'h0000_0020);
        pcSeen = corePc;
        pulse(1);
        pulse(0);
        waitFor(1, lat);
        chk(vectorPc, pcSeen + 13'h1, "wake next address");
        bus(0, IFEV_OFS_CTRL, 0);
        chk(rd, 32'h0000_0024, "wake cause flag");
        bus(1, IFEV_OFS_CTRL, 32'h0000_00A0);
        pulse(1);
        pulse(0);
        waitFor(0, lat);
        chk(vectorPc, IFEV_VECTOR, "wake vector");
        $display("test wake done");
    endtask : test_wake

    task automatic test_rereset();
        bus(1, IFEV_OFS_CTRL, 32'h0000_00E0);
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        bus(0, IFEV_OFS_CTRL, 0);
        chk(rd, 32'h0000_0000, "ctrl after reset");
        $display("test second reset done");
    endtask : test_rereset

    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    initial
    begin
        {rst_b, avs_read, avs_write, external_irq_pin, portChangeIn} = 5'b00000;
        {timer0Overflow, sleepEnter, retCmd} = 3'b000;
        avs_address = 8'h00;
        avs_writedata = 32'h0000_0000;
        periphEvent = '0;
        n_mismatch = 0;
        checks_done = 0;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        test_reset();
        test_flags();
        test_vector();
        test_latency();
        test_wake();
        test_rereset();
        tally_and_finish();
    end
endmodule : tb_interrupt_flag_enable_vectoring
